// File: logic/pmx_pkg.sv
package pmx_pkg;

	// ==========================================
	// Register map
	localparam logic [7:0] OFS_PORT_E_ALT  = 8'h00;
	localparam logic [7:0] OFS_IF_CONFIG   = 8'h04;
	localparam logic [7:0] OFS_FIFO_POL    = 8'h08;
	localparam logic [7:0] OFS_WAKE_CTL    = 8'h0C;
	localparam logic [7:0] OFS_PORT_E_OUT  = 8'h10;
	localparam logic [7:0] OFS_PORT_E_OE   = 8'h14;
	localparam logic [7:0] OFS_STATUS      = 8'h18;
	localparam logic [7:0] OFS_PORT_E_IN   = 8'h1C;

	// ==========================================
	// Reset values
	localparam logic [7:0] RST_PORT_E_ALT  = 8'h00;
	localparam logic [7:0] RST_IF_CONFIG   = 8'h80;
	localparam logic [7:0] RST_FIFO_POL    = 8'h00;
	localparam logic [7:0] RST_WAKE_CTL    = 8'h00;
	localparam logic [7:0] RST_PORT_E_OUT  = 8'h00;
	localparam logic [7:0] RST_PORT_E_OE   = 8'h00;
	localparam logic [5:0] RST_CONTROL     = 6'h3F;
	localparam logic [1:0] PRIME_CYCLES    = 2'h3;

	// ==========================================
	// Field positions
	localparam int IFC_CLK_SRC   = 7;
	localparam int IFC_FREQ48    = 6;
	localparam int IFC_CLK_OE    = 5;
	localparam int IFC_CLK_INV   = 4;
	localparam int POL_READ      = 3;
	localparam int POL_WRITE     = 2;
	localparam int POL_EMPTY     = 1;
	localparam int POL_FULL      = 0;
	localparam int WAKE_POL      = 4;
	localparam int PE_UART0      = 3;
	localparam int PE_UART1      = 4;
	localparam int PE_IRQ6       = 5;
	localparam int PE_T2RELOAD   = 6;
	localparam int PE_ADDR8      = 7;

	typedef enum logic [1:0]
	{
		IFM_PORTS = 2'h0,
		IFM_WAVE  = 2'h2,
		IFM_SLAVE = 2'h3
	} pmx_ifmode_t;

	// ==========================================
	// Helpers
	function automatic logic pmx_pick4(input logic [3:0] v, input logic [1:0] idx);
		return v[idx];
	endfunction : pmx_pick4

endpackage : pmx_pkg

// File: logic/pmx_cfg_if.sv
`timescale 1ns/1ps
interface pmx_cfg_if;
	logic [7:0] port_e_alt_config;
	logic [7:0] interface_config;
	logic [7:0] fifo_pin_polarity;
	logic [7:0] wakeup_control;
	logic [7:0] port_e_gpio_out;
	logic [7:0] port_e_gpio_oe;
	logic [7:0] status;
	logic [7:0] port_e_level;

	modport regs
	(
		output port_e_alt_config, interface_config, fifo_pin_polarity, wakeup_control,
		output port_e_gpio_out, port_e_gpio_oe,
		input  status, port_e_level
	);
	modport core
	(
		input  port_e_alt_config, interface_config, fifo_pin_polarity, wakeup_control,
		input  port_e_gpio_out, port_e_gpio_oe,
		output status, port_e_level
	);
endinterface : pmx_cfg_if

// File: logic/pmx_sync.sv
`timescale 1ns/1ps
module pmx_sync #(
	parameter int W = 8
) (
	input  logic         hclk,
	input  logic         hresetn,
	input  logic         ce,
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pmx_sync_st_t;

	pmx_sync_st_t r;
	pmx_sync_st_t n;

	initial
	begin
		if (W < 1)
			$error("pmx_sync: W must be at least 1");
	end

	// First stage feeds only the second
	always_comb
	begin
		n = r;
		if (ce)
		begin
			n.s1 = d;
			n.s2 = r.s1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			r <= '0;
		else
			r <= n;
	end

	assign q = r.s2;
endmodule : pmx_sync

// File: logic/pmx_regs.sv
`timescale 1ns/1ps
module pmx_regs
	import pmx_pkg::*;
(
	input  logic        hclk,
	input  logic        hresetn,
	input  logic        ce,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic        hresp,
	output logic [31:0] hrdata,
	pmx_cfg_if.regs     cfg
);
	typedef struct packed
	{
		logic        pend;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [7:0]  alt;
		logic [7:0]  ifc;
		logic [7:0]  pol;
		logic [7:0]  wake;
		logic [7:0]  gout;
		logic [7:0]  goe;
		logic [31:0] rdata;
	} pmx_regs_st_t;

	pmx_regs_st_t r;
	pmx_regs_st_t n;

	// ==========================================
	// Bus slave
	always_comb
	begin
		logic [7:0] rv;
		rv = 8'h00;
		n = r;
		if (ce)
		begin
			// Write lands in the data phase
			if (r.pend && r.pwrite)
			begin
				case (r.paddr)
					OFS_PORT_E_ALT: n.alt  = hwdata[7:0];
					OFS_IF_CONFIG:  n.ifc  = hwdata[7:0];
					OFS_FIFO_POL:   n.pol  = hwdata[7:0];
					OFS_WAKE_CTL:   n.wake = hwdata[7:0];
					OFS_PORT_E_OUT: n.gout = hwdata[7:0];
					OFS_PORT_E_OE:  n.goe  = hwdata[7:0];
					default:        n.alt  = n.alt;
				endcase
			end
			n.pend = hsel && htrans[1] && hready;
			n.pwrite = hwrite;
			n.paddr = haddr[7:0];
			// Read sampled after the write above, so back-to-back sees new data
			if (hsel && htrans[1] && hready && !hwrite)
			begin
				case (haddr[7:0])
					OFS_PORT_E_ALT: rv = n.alt;
					OFS_IF_CONFIG:  rv = n.ifc;
					OFS_FIFO_POL:   rv = n.pol;
					OFS_WAKE_CTL:   rv = n.wake;
					OFS_PORT_E_OUT: rv = n.gout;
					OFS_PORT_E_OE:  rv = n.goe;
					OFS_STATUS:     rv = cfg.status;
					OFS_PORT_E_IN:  rv = cfg.port_e_level;
					default:        rv = 8'h00;
				endcase
				n.rdata = {24'h000000, rv};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r       <= '0;
			r.alt   <= RST_PORT_E_ALT;
			r.ifc   <= RST_IF_CONFIG;
			r.pol   <= RST_FIFO_POL;
			r.wake  <= RST_WAKE_CTL;
			r.gout  <= RST_PORT_E_OUT;
			r.goe   <= RST_PORT_E_OE;
		end
		else
			r <= n;
	end

	// Stalls the master while frozen so no transfer is lost
	assign hreadyout             = ce;
	assign hresp                 = 1'b0;
	assign hrdata                = r.rdata;
	assign cfg.port_e_alt_config = r.alt;
	assign cfg.interface_config  = r.ifc;
	assign cfg.fifo_pin_polarity = r.pol;
	assign cfg.wakeup_control    = r.wake;
	assign cfg.port_e_gpio_out   = r.gout;
	assign cfg.port_e_gpio_oe    = r.goe;
endmodule : pmx_regs

// File: logic/pmx_top.sv
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - Port E pins are GPIO unless alt bit set
// - UART0 sync pin carries data in mode0, else 1
// - UART1 sync pin carries data in mode0, else high
// - Interrupt 6 requests on rising edge
// - Timer 2 reloads on falling strobe when enabled
// - Top port E pin drives waveform address bit8
// - Mode picks ready0 or read strobe, polarity bit3
// - Mode picks ready1 or write strobe, polarity bit2
// - Ready pins 2-5 are always inputs
// - Flag A shows selected FIFO programmable flag
// - Flag B shows selected FIFO full flag
// - Flag C shows selected FIFO empty flag
// - Six control outputs, high after reset
// - Internal clock may drive pin, 30/48 select
// - Config bit4 inverts the interface clock
// - FIFO and waveform signals timed to interface clock
// - Interrupt 4 requests on rising edge
// - Interrupt 5 requests on falling edge
// - Timers count pins only when select bit set
// - UART transmit is clock in sync, data async
// - Resume pin wakes suspended core, polarity bit4
// - Asserted resume pin blocks suspend
module pmx_top
	import pmx_pkg::*;
(
	input  logic        hclk,
	input  logic        hresetn,
	input  logic        ce,
	input  logic        hsel,
	input  logic [31:0] haddr,
	input  logic [1:0]  htrans,
	input  logic        hwrite,
	input  logic [2:0]  hsize,
	input  logic [31:0] hwdata,
	input  logic        hready,
	output logic        hreadyout,
	output logic        hresp,
	output logic [31:0] hrdata,
	input  logic [7:0]  port_e_in,
	output logic [7:0]  port_e_out,
	output logic [7:0]  port_e_oe,
	input  logic [2:0]  timer_overflow,
	input  logic [1:0]  uart_mode0,
	input  logic [1:0]  uart_sync_data,
	input  logic [1:0]  uart_shift_clock,
	input  logic [1:0]  uart_tx_data,
	output logic        uart0_transmit,
	output logic        uart1_transmit,
	input  logic        uart0_receive,
	input  logic        uart1_receive,
	output logic [1:0]  uart_rx_data,
	input  logic        waveform_addr_bit8,
	input  logic [5:0]  ready_pins,
	output logic [5:0]  waveform_ready,
	output logic        fifo_read_strobe,
	output logic        fifo_write_strobe,
	input  logic [5:0]  waveform_ctl,
	output logic [5:0]  control_pins,
	input  logic [1:0]  fifo_select_addr,
	input  logic [3:0]  fifo_prog_flag,
	input  logic [3:0]  fifo_full,
	input  logic [3:0]  fifo_empty,
	output logic        interface_clock_internal,
	output logic        interface_clock_oe,
	output logic        interface_clock_sel48,
	output logic        interface_clock_invert,
	input  logic        ext_irq4,
	input  logic        ext_irq5_n,
	output logic        ext_irq4_req,
	output logic        ext_irq5_req,
	output logic        ext_irq6_req,
	input  logic [2:0]  timer_pins,
	input  logic [2:0]  timer_count_select,
	output logic [2:0]  timer_count_pulse,
	input  logic        timer2_ext_reload_enable,
	output logic        timer2_reload_pulse,
	input  logic        resume_pin,
	input  logic        core_suspended,
	output logic        resume_wake_pulse,
	output logic        suspend_inhibit,
	output logic [3:0]  mem_strobes_n
);
	localparam int SYNC_W = 24;

	typedef struct packed
	{
		logic [1:0] prime;
		logic       irq4_q;
		logic       irq5n_q;
		logic       irq6_q;
		logic       t2rl_q;
		logic [2:0] tpin_q;
		logic       wake_q;
		logic [7:0] pe_out;
		logic [7:0] pe_oe;
		logic [5:0] ctl;
		logic [5:0] wready;
		logic       rd_stb;
		logic       wr_stb;
		logic [1:0] utx;
		logic [1:0] urx;
		logic       irq4_p;
		logic       irq5_p;
		logic       irq6_p;
		logic       t2rl_p;
		logic [2:0] tcnt_p;
		logic       wake_p;
		logic       inhibit;
		logic [3:0] interface_clock;
	} pmx_top_st_t;

	pmx_top_st_t r;
	pmx_top_st_t n;
	pmx_cfg_if   cfg ();

	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] syn;
	logic [7:0]        pe_s;
	logic [1:0]        rx_s;
	logic [1:0]        fsel_s;
	logic [5:0]        rdy_s;
	logic              irq4_s;
	logic              irq5n_s;
	logic [2:0]        tpin_s;
	logic              wake_s;
	logic              slave;
	logic              wake_act;

	// ==========================================
	// Pin synchronisers
	assign raw = {resume_pin, timer_pins, ext_irq5_n, ext_irq4, ready_pins,
		fifo_select_addr, uart1_receive, uart0_receive, port_e_in};

	pmx_sync #(.W(SYNC_W)) u_sync
	(
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.d       (raw),
		.q       (syn)
	);

	assign pe_s    = syn[7:0];
	assign rx_s    = syn[9:8];
	assign fsel_s  = syn[11:10];
	assign rdy_s   = syn[17:12];
	assign irq4_s  = syn[18];
	assign irq5n_s = syn[19];
	assign tpin_s  = syn[22:20];
	assign wake_s  = syn[23];

	// ==========================================
	// Register bus
	pmx_regs u_regs
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.cfg       (cfg)
	);

	assign slave    = cfg.interface_config[1:0] == IFM_SLAVE;
	assign wake_act = wake_s == cfg.wakeup_control[WAKE_POL];

	assign cfg.status       = {4'h0, r.inhibit, fsel_s, slave};
	assign cfg.port_e_level = pe_s;

	// ==========================================
	// Next state
	always_comb
	begin
		logic live;
		live = r.prime == PRIME_CYCLES;
		n = r;
		if (ce)
		begin
			// Edge detectors wait until synchronisers hold real pin levels
			if (!live)
				n.prime = r.prime + 2'h1;

			// Port E: GPIO by default, alternate function per bit
			n.pe_out = cfg.port_e_gpio_out;
			n.pe_oe  = cfg.port_e_gpio_oe;
			for (int i = 0; i < 3; i++)
			begin
				if (cfg.port_e_alt_config[i])
				begin
					n.pe_out[i] = timer_overflow[i];
					n.pe_oe[i]  = 1'b1;
				end
			end
			if (cfg.port_e_alt_config[PE_UART0])
			begin
				n.pe_out[PE_UART0] = uart_mode0[0] ? uart_sync_data[0] : 1'b1;
				n.pe_oe[PE_UART0]  = 1'b1;
			end
			if (cfg.port_e_alt_config[PE_UART1])
			begin
				n.pe_out[PE_UART1] = uart_mode0[1] ? uart_sync_data[1] : 1'b1;
				n.pe_oe[PE_UART1]  = 1'b1;
			end
			if (cfg.port_e_alt_config[PE_IRQ6])
			begin
				n.pe_out[PE_IRQ6] = 1'b0;
				n.pe_oe[PE_IRQ6]  = 1'b0;
			end
			if (cfg.port_e_alt_config[PE_T2RELOAD])
			begin
				n.pe_out[PE_T2RELOAD] = 1'b0;
				n.pe_oe[PE_T2RELOAD]  = 1'b0;
			end
			if (cfg.port_e_alt_config[PE_ADDR8])
			begin
				n.pe_out[PE_ADDR8] = waveform_addr_bit8;
				n.pe_oe[PE_ADDR8]  = 1'b1;
			end

			// Edge events, one cycle each
			n.irq4_q  = irq4_s;
			n.irq5n_q = irq5n_s;
			n.irq6_q  = pe_s[PE_IRQ6];
			n.t2rl_q  = pe_s[PE_T2RELOAD];
			n.tpin_q  = tpin_s;
			n.wake_q  = wake_act;
			n.irq4_p  = live && irq4_s && !r.irq4_q;
			n.irq5_p  = live && !irq5n_s && r.irq5n_q;
			n.irq6_p  = live && cfg.port_e_alt_config[PE_IRQ6]
				&& pe_s[PE_IRQ6] && !r.irq6_q;
			n.t2rl_p  = live && cfg.port_e_alt_config[PE_T2RELOAD]
				&& timer2_ext_reload_enable
				&& !pe_s[PE_T2RELOAD] && r.t2rl_q;
			n.tcnt_p  = live ? (timer_count_select & ~tpin_s & r.tpin_q) : 3'h0;

			// Resume pin: wake on assertion while suspended
			n.wake_p  = live && core_suspended && wake_act && !r.wake_q;
			n.inhibit = wake_act;

			// UART pins
			for (int u = 0; u < 2; u++)
			begin
				n.utx[u] = uart_mode0[u] ? uart_shift_clock[u] : uart_tx_data[u];
			end
			n.urx = rx_s;

			// Ready pins and slave strobes; sampled against interface clock upstream
			n.rd_stb = slave && (rdy_s[0] == cfg.fifo_pin_polarity[POL_READ]);
			n.wr_stb = slave && (rdy_s[1] == cfg.fifo_pin_polarity[POL_WRITE]);
			n.wready = {rdy_s[5:2], slave ? 2'h0 : rdy_s[1:0]};

			// Control pins: engine outputs, or flags in slave mode
			n.ctl = waveform_ctl;
			if (slave)
			begin
				n.ctl[0] = pmx_pick4(fifo_prog_flag, fsel_s);
				n.ctl[1] = pmx_pick4(fifo_full, fsel_s)
					== cfg.fifo_pin_polarity[POL_FULL];
				n.ctl[2] = pmx_pick4(fifo_empty, fsel_s)
					== cfg.fifo_pin_polarity[POL_EMPTY];
			end

			// Interface clock controls
			n.interface_clock[0] = cfg.interface_config[IFC_CLK_SRC];
			n.interface_clock[1] = cfg.interface_config[IFC_CLK_SRC]
				&& cfg.interface_config[IFC_CLK_OE];
			n.interface_clock[2] = cfg.interface_config[IFC_FREQ48];
			n.interface_clock[3] = cfg.interface_config[IFC_CLK_INV];
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r         <= '0;
			r.ctl     <= RST_CONTROL;
			r.utx     <= 2'h3;
			r.irq5n_q <= 1'b1;
			r.interface_clock   <= 4'h1;
		end
		else
			r <= n;
	end

	// ==========================================
	// Outputs
	assign port_e_out               = r.pe_out;
	assign port_e_oe                = r.pe_oe;
	assign uart0_transmit           = r.utx[0];
	assign uart1_transmit           = r.utx[1];
	assign uart_rx_data             = r.urx;
	assign waveform_ready           = r.wready;
	assign fifo_read_strobe         = r.rd_stb;
	assign fifo_write_strobe        = r.wr_stb;
	assign control_pins             = r.ctl;
	assign interface_clock_internal = r.interface_clock[0];
	assign interface_clock_oe       = r.interface_clock[1];
	assign interface_clock_sel48    = r.interface_clock[2];
	assign interface_clock_invert   = r.interface_clock[3];
	assign ext_irq4_req             = r.irq4_p;
	assign ext_irq5_req             = r.irq5_p;
	assign ext_irq6_req             = r.irq6_p;
	assign timer_count_pulse        = r.tcnt_p;
	assign timer2_reload_pulse      = r.t2rl_p;
	assign resume_wake_pulse        = r.wake_p;
	assign suspend_inhibit          = r.inhibit;
	// External memory strobes idle inactive
	assign mem_strobes_n            = 4'hF;
endmodule : pmx_top

// File: dv/pmx_top_sva.sv
`timescale 1ns/1ps
// ==========
// Pin routing checks
module pmx_top_sva (
	input logic       hclk,
	input logic       hresetn,
	input logic       ext_irq4,
	input logic       ext_irq5_n,
	input logic       ext_irq4_req,
	input logic       ext_irq5_req,
	input logic [5:0] control_pins,
	input logic       uart0_transmit,
	input logic       uart1_transmit,
	input logic [1:0] uart_mode0,
	input logic [1:0] uart_shift_clock,
	input logic [1:0] uart_tx_data,
	input logic [5:0] ready_pins,
	input logic [5:0] waveform_ready,
	input logic       fifo_read_strobe,
	input logic       fifo_write_strobe,
	input logic       interface_clock_internal,
	input logic       interface_clock_oe,
	input logic [2:0] timer_count_pulse,
	input logic [2:0] timer_count_select,
	input logic       timer2_reload_pulse,
	input logic       timer2_ext_reload_enable
);
	logic [2:0] live_r;
	logic       ok;
	logic [1:0] tx_src;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Past values are only trusted once the pipeline refilled after reset
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			live_r <= 3'h0;
		else if (live_r != 3'h7)
			live_r <= live_r + 3'h1;
	assign ok = live_r[2];
	assign tx_src = uart_mode0 & uart_shift_clock | ~uart_mode0 & uart_tx_data;
	sequence s_rise4;
		$rose(ext_irq4) ##1 ext_irq4 [*2];
	endsequence
	sequence s_fall5;
		$fell(ext_irq5_n) ##1 !ext_irq5_n [*2];
	endsequence
	AST_IRQ4: assert property (ok ##0 s_rise4 |-> ##[0:2] ext_irq4_req)
		else $error("irq4 request missing");
	AST_IRQ5: assert property (ok ##0 s_fall5 |-> ##[0:2] ext_irq5_req)
		else $error("irq5 request missing");
	AST_PULSE: assert property (ext_irq4_req || ext_irq5_req |=> !(ext_irq4_req || ext_irq5_req))
		else $error("irq request longer than one cycle");
	AST_RESET: assert property ($rose(hresetn) |-> control_pins == 6'h3F && uart0_transmit
		&& uart1_transmit && interface_clock_internal && !interface_clock_oe)
		else $error("reset levels wrong");
	AST_READY: assert property (ok |-> waveform_ready[5:2] == $past(ready_pins[5:2], 3))
		else $error("ready inputs not passed through");
	AST_UART: assert property (ok |-> {uart1_transmit, uart0_transmit} == $past(tx_src))
		else $error("uart transmit source wrong");
	AST_STROBE: assert property (fifo_read_strobe || fifo_write_strobe |-> waveform_ready[1:0] == 2'h0)
		else $error("strobe and ready both active");
	AST_INTERFACE_CLOCK: assert property (interface_clock_oe |-> interface_clock_internal)
		else $error("clock output without internal source");
	AST_TIMER: assert property (ok |-> (timer_count_pulse & ~$past(timer_count_select)) == 3'h0)
		else $error("timer counted unselected pin");
	AST_RELOAD: assert property (timer2_reload_pulse |-> $past(timer2_ext_reload_enable))
		else $error("reload while disabled");
endmodule : pmx_top_sva

// File: dv/pmx_far.sv
`timescale 1ns/1ps
// ==========
// Far side: FIFO master, serial peers, interrupt sources
module pmx_far (
	input  logic       hclk,
	output logic [5:0] ready_pins,
	output logic [1:0] fifo_select_addr,
	output logic       ext_irq4,
	output logic       ext_irq5_n,
	output logic [2:0] timer_pins,
	output logic       resume_pin,
	output logic       uart0_receive,
	output logic       uart1_receive,
	output logic [7:0] pe_far
);
	logic [23:0] v_r = 24'h00023F;
	// Strobe levels are polarity-aware, set by the caller
	assign ready_pins = v_r[5:0];
	assign fifo_select_addr = v_r[7:6];
	assign ext_irq4 = v_r[8];
	assign ext_irq5_n = v_r[9];
	assign timer_pins = v_r[12:10];
	assign resume_pin = v_r[13];
	assign uart0_receive = v_r[14];
	assign uart1_receive = v_r[15];
	assign pe_far = v_r[23:16];
	// Levels held until next call; caller leaves at least 3 cycles
	task automatic put(input logic [23:0] v);
		@(posedge hclk);
		v_r <= v;
	endtask : put
endmodule : pmx_far

// File: dv/port_e_and_interface_pin_routing_tb.sv
`timescale 1ns/1ps
// ==========
// Bench top
module port_e_and_interface_pin_routing_tb;
	import pmx_pkg::*;
	localparam logic [23:0] IDLE = 24'h00023F;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] timer_overflow = 3'h5;
	logic [1:0] uart_mode0 = 2'h0;
	logic [1:0] uart_sync_data = 2'h0;
	logic [1:0] uart_shift_clock = 2'h0;
	logic [1:0] uart_tx_data = 2'h3;
	logic waveform_addr_bit8 = 1'b0;
	logic [5:0] waveform_ctl = 6'h2A;
	logic [3:0] fifo_prog_flag = 4'h6;
	logic [3:0] fifo_full = 4'h3;
	logic [3:0] fifo_empty = 4'h5;
	logic [2:0] timer_count_select = 3'h3;
	logic timer2_ext_reload_enable = 1'b1;
	logic core_suspended = 1'b1;
	logic hreadyout, uart0_transmit, uart1_transmit, uart0_receive, uart1_receive;
	logic fifo_read_strobe, fifo_write_strobe, interface_clock_internal, interface_clock_oe;
	logic interface_clock_sel48, interface_clock_invert, ext_irq4, ext_irq5_n, resume_pin;
	logic ext_irq4_req, ext_irq5_req, ext_irq6_req, timer2_reload_pulse;
	logic resume_wake_pulse, suspend_inhibit, hresp;
	logic [3:0] mem_strobes_n;
	logic [31:0] hrdata, q;
	logic [7:0] port_e_in, port_e_out, port_e_oe, pe_far, pv;
	logic [5:0] ready_pins, waveform_ready, control_pins;
	logic [1:0] uart_rx_data, fifo_select_addr;
	logic [2:0] timer_pins, timer_count_pulse;
	logic [7:0] ofs [7] = '{8'h20, OFS_PORT_E_ALT, OFS_IF_CONFIG, OFS_FIFO_POL,
		OFS_WAKE_CTL, OFS_PORT_E_OUT, OFS_PORT_E_OE};
	logic [7:0] rst [7] = '{8'h00, RST_PORT_E_ALT, RST_IF_CONFIG, RST_FIFO_POL,
		RST_WAKE_CTL, RST_PORT_E_OUT, RST_PORT_E_OE};
	logic [4:0] am [4] = '{5'h0F, 5'h08, 5'h11, 5'h1A};
	logic [7:0] ae [4] = '{8'h9D, 8'h15, 8'h8D, 8'h0D};
	logic [23:0] evv [10] = '{24'h33F, IDLE, 24'h03F, IDLE, 24'h20023F, 24'h60023F,
		24'h20023F, 24'h1E3F, IDLE, 24'h223F};
	logic [31:0] eve [10] = '{32'h1, 0, 32'h10, 0, 32'h100, 0, 32'h1000000, 0, 32'h11000,
		32'h10000000};
	logic [7:0] pol [2] = '{8'h0C, 8'h03};
	logic [7:0] ic [4] = '{8'hF0, 8'h10, 8'hA0, 8'h50};
	int pc [8];
	int err_count = 0;
	int cmp_count = 0;

	always #10 hclk = ~hclk;
	// No pull on port E: the far side always drives when the block does not
	assign port_e_in = port_e_oe & port_e_out | ~port_e_oe & pe_far;
	assign pv = {resume_wake_pulse, timer2_reload_pulse, timer_count_pulse, ext_irq6_req,
		ext_irq5_req, ext_irq4_req};
	// Pulses counted on the falling edge, where they are settled
	always @(negedge hclk)
		foreach (pc[i])
			pc[i] += (pv[i] !== 1'b0);

	pmx_top i_pmx_top (.ce(1'b1), .hsel(1'b1), .hsize(3'h2), .hready(hreadyout), .*);
	pmx_far i_pmx_far (.*);

	// ==========
	// Tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1)
		begin
			err_count++;
			give_verdict();
		end
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask : bus

	task automatic ev(input logic [23:0] v, input logic [31:0] exp, input logic inh);
		logic [31:0] seen;
		foreach (pc[i])
			pc[i] = 0;
		i_pmx_far.put(v);
		repeat (5) @(posedge hclk);
		foreach (pc[i])
			seen[4*i+:4] = pc[i][3:0];
		check("pulses", seen, exp);
		check("inhibit", suspend_inhibit, inh);
	endtask : ev

	// ==========
	// Main sequence
	initial
	begin
		repeat (10) @(posedge hclk);
		check("ctl", control_pins, RST_CONTROL);
		check("interface_clock", {interface_clock_internal, interface_clock_oe}, 2'h2);
		check("pe oe", port_e_oe, 8'h00);
		check("idle", {hresp, mem_strobes_n}, 5'h0F);
		hresetn <= 1'b1;
		bus(1, 8'h20, 32'hFF);
		foreach (ofs[i])
		begin
			bus(0, ofs[i], 0);
			check("reg", q, {24'h0, rst[i]});
		end
		$display("reset test done");
		bus(1, OFS_PORT_E_OE, 32'hFF);
		bus(1, OFS_PORT_E_OUT, 32'hA5);
		ev(IDLE, 0, 1'b1);
		check("pe out", {port_e_oe, port_e_out}, 16'hFFA5);
		bus(0, OFS_PORT_E_IN, 0);
		check("pe in", q, 32'hA5);
		bus(1, OFS_PORT_E_OE, 32'h00);
		ev(IDLE | 24'h5A0000, 0, 1'b1);
		bus(0, OFS_PORT_E_IN, 0);
		check("pe in", q, 32'h5A);
		bus(1, OFS_PORT_E_ALT, 32'h9F);
		foreach (am[i])
		begin
			{uart_mode0, uart_sync_data, waveform_addr_bit8} <= am[i];
			ev(IDLE, 0, 1'b1);
			check("pe alt", {port_e_oe & 8'h9F, port_e_out & 8'h9F}, {8'h9F, ae[i]});
		end
		$display("port test done");
		bus(1, OFS_PORT_E_ALT, 32'h60);
		bus(1, OFS_WAKE_CTL, 32'h10);
		foreach (evv[i])
			ev(evv[i], eve[i], evv[i][13]);
		bus(1, OFS_WAKE_CTL, 32'h00);
		ev(IDLE, 32'h10000000, 1'b1);
		ev(24'h223F, 0, 1'b0);
		core_suspended <= 1'b0;
		ev(IDLE, 0, 1'b1);
		timer2_ext_reload_enable <= 1'b0;
		ev(24'h40023F, 0, 1'b1);
		ev(IDLE, 0, 1'b1);
		bus(1, OFS_PORT_E_ALT, 32'h00);
		timer2_ext_reload_enable <= 1'b1;
		ev(24'h60023F, 0, 1'b1);
		ev(IDLE, 0, 1'b1);
		$display("event test done");
		bus(1, OFS_IF_CONFIG, 32'h83);
		foreach (pol[k])
		begin
			bus(1, OFS_FIFO_POL, {24'h0, pol[k]});
			for (int a = 0; a < 4; a++)
			begin
				ev(24'h229 | (24'(a) << 6), 0, 1'b1);
				check("strobe", {fifo_read_strobe, fifo_write_strobe, waveform_ready},
					{pol[k][3], ~pol[k][2], 6'h28});
				check("flags", control_pins, {3'h5, {fifo_empty[a], fifo_full[a]}
					^ {2{~pol[k][0]}}, fifo_prog_flag[a]});
			end
		end
		bus(0, OFS_STATUS, 0);
		check("status", q, 32'h0F);
		bus(1, OFS_IF_CONFIG, 32'h82);
		ev(24'h229, 0, 1'b1);
		check("wave", {fifo_read_strobe, fifo_write_strobe, waveform_ready, control_pins},
			{2'h0, 6'h29, 6'h2A});
		$display("fifo test done");
		foreach (ic[i])
		begin
			bus(1, OFS_IF_CONFIG, {24'h0, ic[i]});
			ev(24'h229, 0, 1'b1);
			check("interface_clock", {interface_clock_internal, interface_clock_sel48,
				interface_clock_oe, interface_clock_invert}, ic[i][7:4]);
		end
		uart_mode0 <= 2'h1;
		uart_shift_clock <= 2'h1;
		uart_tx_data <= 2'h2;
		ev(24'h4229, 0, 1'b1);
		check("uart", {uart1_transmit, uart0_transmit, uart_rx_data}, 4'hD);
		uart_shift_clock <= 2'h2;
		uart_tx_data <= 2'h1;
		ev(24'h8229, 0, 1'b1);
		check("uart", {uart1_transmit, uart0_transmit, uart_rx_data}, 4'h2);
		$display("clock and uart test done");
		give_verdict();
	end
endmodule : port_e_and_interface_pin_routing_tb

bind pmx_top pmx_top_sva i_pmx_top_sva (.hclk, .hresetn, .ext_irq4, .ext_irq5_n,
	.ext_irq4_req, .ext_irq5_req, .control_pins, .uart0_transmit, .uart1_transmit,
	.uart_mode0, .uart_shift_clock, .uart_tx_data, .ready_pins, .waveform_ready,
	.fifo_read_strobe, .fifo_write_strobe, .interface_clock_internal, .interface_clock_oe,
	.timer_count_pulse, .timer_count_select, .timer2_reload_pulse, .timer2_ext_reload_enable);
